// ===== src/emask_consts.vh
// Constants shared by the error-count qualification logic
`ifndef EMASK_CONSTS_VH
`define EMASK_CONSTS_VH

// Test pattern type codes
`define EMASK_PAT_PRBS 3'h0
`define EMASK_PAT_DATA 3'h1
`define EMASK_PAT_ZSUB 3'h2
`define EMASK_PAT_MIXED 3'h3

// Clock source codes
`define EMASK_CLK_EXT 2'h0
`define EMASK_CLK_REC 2'h1
`define EMASK_CLK_CDR 2'h2

// Sync control codes; only frame mode uses the frame settings
`define EMASK_SYNC_NORMAL 2'h0
`define EMASK_SYNC_FRAME 2'h2

// Auxiliary input function code for the external mask
`define EMASK_AUX_EXTMASK 2'h1

// Skip filter link generation codes, first to fifth
`define EMASK_GEN1 3'h0
`define EMASK_GEN2 3'h1
`define EMASK_GEN3 3'h2
`define EMASK_GEN4 3'h3
`define EMASK_GEN5 3'h4

// Skip ordered set head words and compare masks
`define EMASK_SKP_8B10B 32'h3E8F43D0
`define EMASK_SKP_8B10B_MSK 32'hFFFFFFFC
`define EMASK_SKP_128B 32'h6AAAAAAA
`define EMASK_SKP_G5 32'h66666666
`define EMASK_SKP_FULL_MSK 32'hFFFFFFFF

// Skip ordered set length in received words
`define EMASK_SKP_WORDS_8B 3'h2
`define EMASK_SKP_WORDS_128B 3'h5

// Block window: base length range per channel and largest step shift
`define EMASK_BW_BASE_LEN 30'h0200000
`define EMASK_BW_MAX_SHIFT 3'h7

// Pattern bits carried per received word per channel
`define EMASK_WORD_BITS 30'h0000020

`endif

// ===== src/emask_skip_det.v
// Skip ordered set recogniser for the first data input
`timescale 1ns/1ps
`include "emask_consts.vh"

module emask_skip_det (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Control
    input wire enable,
    input wire [2:0] gen,
    // Received stream
    input wire word_valid,
    input wire [31:0] rx_word,
    // Current word belongs to a skip ordered set
    output wire skip_hit
);
    reg [2:0] left_q;
    reg [2:0] left_d;
    reg [31:0] head;
    reg [31:0] msk;
    reg [2:0] words;
    wire head_hit;

    // Head word and length per generation
    always @* begin
        if (gen == `EMASK_GEN1 || gen == `EMASK_GEN2) begin
            head = `EMASK_SKP_8B10B;
            msk = `EMASK_SKP_8B10B_MSK;
            words = `EMASK_SKP_WORDS_8B;
        end else if (gen == `EMASK_GEN5) begin
            head = `EMASK_SKP_G5;
            msk = `EMASK_SKP_FULL_MSK;
            words = `EMASK_SKP_WORDS_128B;
        end else begin
            head = `EMASK_SKP_128B;
            msk = `EMASK_SKP_FULL_MSK;
            words = `EMASK_SKP_WORDS_128B;
        end
    end

    assign head_hit = enable && word_valid && left_q == 3'h0 &&
                      (rx_word & msk) == head;
    assign skip_hit = head_hit || (enable && word_valid && left_q != 3'h0);

    // Remaining words of the set after its head
    always @* begin
        left_d = left_q;
        if (!enable) begin
            left_d = 3'h0;
        end else if (head_hit) begin
            left_d = words - 3'h1;
        end else if (word_valid && left_q != 3'h0) begin
            left_d = left_q - 3'h1;
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            left_q <= 3'h0;
        end else begin
            left_q <= left_d;
        end
    end
endmodule

// ===== src/emask_bwin.v
// Block window mask store and per-bit lookup
`timescale 1ns/1ps
`include "emask_consts.vh"

module emask_bwin #(
    parameter DEPTH = 2097152,
    parameter AW = 21,
    parameter LW = 30
) (
    // Clock
    input wire mclk,
    // Mask store write port
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire wr_data,
    // Pattern geometry
    input wire [LW-1:0] len_ch,
    input wire [LW-1:0] pos,
    // One bit per route, high means suppress
    output reg [31:0] blocked
);
    reg mem [0:DEPTH-1];
    reg [2:0] shift;
    reg [LW-1:0] idx;
    integer i;

    // Step doubles with each doubling of the per-channel length range
    function [2:0] step_shift;
        input [LW-1:0] len;
        reg [LW-1:0] lim;
        integer k;
        begin
            lim = `EMASK_BW_BASE_LEN;
            step_shift = 3'h0;
            for (k = 0; k < 7; k = k + 1) begin
                if (len > lim) begin
                    step_shift = step_shift + 3'h1;
                end
                lim = {lim[LW-2:0], 1'b0};
            end
        end
    endfunction

    // Mask writes; no reset since the store is plain memory
    always @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Each route looks up the mask bit covering its pattern bit
    always @* begin
        shift = step_shift(len_ch);
        idx = {LW{1'b0}};
        blocked = 32'h00000000;
        for (i = 0; i < 32; i = i + 1) begin
            idx = pos + i[LW-1:0];
            if (idx >= len_ch) begin
                idx = idx - len_ch;
            end
            idx = idx >> shift;
            blocked[i] = mem[idx[AW-1:0]];
        end
    end
endmodule

// ===== src/emask_top.v
// Error-count qualification: skip filter, block window, route and external mask
`timescale 1ns/1ps
`include "emask_consts.vh"

module emask_top #(
    parameter BW_DEPTH = 2097152,
    parameter BW_AW = 21,
    parameter LW = 30,
    parameter CW = 48
) (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Pattern and clocking setup
    input wire [2:0] pat_type,
    input wire [1:0] clk_src,
    input wire in_sel,
    input wire merge_en,
    input wire auto_order,
    input wire [LW-1:0] pat_len,
    // Skip filter setup
    input wire skip_en,
    input wire [2:0] skip_gen,
    // Frame sync setup
    input wire [1:0] sync_mode,
    input wire [LW-1:0] frame_len,
    input wire [LW-1:0] frame_start,
    input wire [31:0] frame_mask,
    // Block window setup and mask store
    input wire bwin_en,
    input wire bw_wr_en,
    input wire [BW_AW-1:0] bw_wr_addr,
    input wire bw_wr_data,
    // Route mask setup
    input wire route_en,
    input wire [31:0] route_mask,
    // External mask
    input wire [1:0] aux_func,
    input wire ext_en,
    input wire ext_mask_pin,
    // Received and expected words
    input wire word_valid,
    input wire sync_restart,
    input wire [31:0] rx_a,
    input wire [31:0] rx_b,
    input wire [31:0] exp_a,
    input wire [31:0] exp_b,
    // Results
    output reg [CW-1:0] err_count_q,
    output reg [6:0] err_add_q,
    output reg exp_hold_q,
    output reg swap_q,
    // Effective settings
    output reg skip_on_q,
    output reg bwin_on_q,
    output reg ext_on_q,
    output reg frame_on_q,
    output reg [LW-1:0] frame_len_q,
    output reg [LW-1:0] frame_start_q,
    output reg [31:0] frame_mask_q
);
    // Pin synchroniser stages
    reg ext_s1_q;
    reg ext_s2_q;

    // Pattern position and channel order
    reg [LW-1:0] pos_q;
    reg [LW-1:0] pos_d;
    reg [LW-1:0] pos_nx;
    reg swap_d;

    // Mask qualification and datapath
    reg [31:0] keep;
    wire pat_rand;
    wire skip_ok;
    wire bw_ok;
    wire ext_ok;
    wire skip_hit;
    wire [31:0] bw_blocked;
    wire [LW-1:0] len_ch;
    wire [31:0] ch0;
    wire [31:0] ch1;
    wire [31:0] err0;
    wire [31:0] err1;
    wire [6:0] add;

    // Qualified mask terms and count arithmetic
    wire [5:0] ones0;
    wire [5:0] ones1;
    wire [CW-1:0] add_wide;
    wire [CW-1:0] headroom;
    wire skip_pat_ok;
    wire skip_path_ok;
    wire ext_act;
    wire frame_sel;

    // Ones in a word
    function [5:0] ones;
        input [31:0] w;
        integer k;
        begin
            ones = 6'h00;
            for (k = 0; k < 32; k = k + 1) begin
                ones = ones + {5'h00, w[k]};
            end
        end
    endfunction

    // External mask pin comes from outside; two stages before use
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_mask_pin;
            ext_s2_q <= ext_s1_q;
        end
    end

    // Mode qualification
    assign pat_rand = pat_type == `EMASK_PAT_PRBS ||
                      pat_type == `EMASK_PAT_MIXED;
    // Only a plain data pattern can carry encoded skip sets
    assign skip_pat_ok = !pat_rand &&
                         pat_type != `EMASK_PAT_ZSUB &&
                         pat_type == `EMASK_PAT_DATA;
    // Recovered data clock comes from the first input alone
    assign skip_path_ok = !in_sel && clk_src == `EMASK_CLK_CDR &&
                          !merge_en;
    // Requests that break a precondition are simply not honoured
    assign skip_ok = skip_en && skip_pat_ok && skip_path_ok;
    assign bw_ok = bwin_en && !pat_rand;
    assign ext_ok = ext_en && aux_func == `EMASK_AUX_EXTMASK;
    // Synchronised pin only counts while the mask is usable
    assign ext_act = ext_ok && ext_s2_q;
    // Frame settings matter only in frame sync mode
    assign frame_sel = sync_mode == `EMASK_SYNC_FRAME;

    // Per-channel length; merged pattern splits evenly over two inputs
    assign len_ch = merge_en ? {1'b0, pat_len[LW-1:1]} : pat_len;

    // Skip recogniser sees the first input only
    emask_skip_det u_skip (
        .mclk(mclk),
        .rst_n(rst_n),
        .enable(skip_ok),
        .gen(skip_gen),
        .word_valid(word_valid),
        .rx_word(rx_a),
        .skip_hit(skip_hit)
    );

    // Per-channel position divides out N, scaling range and step alike
    emask_bwin #(
        .DEPTH(BW_DEPTH),
        .AW(BW_AW),
        .LW(LW)
    ) u_bwin (
        .mclk(mclk),
        .wr_en(bw_wr_en),
        .wr_addr(bw_wr_addr),
        .wr_data(bw_wr_data),
        .len_ch(len_ch),
        .pos(pos_q),
        .blocked(bw_blocked)
    );

    // Channel order; swapped halves are put back before comparison
    assign ch0 = swap_q ? rx_b : rx_a;
    assign ch1 = swap_q ? rx_a : rx_b;
    assign err0 = ch0 ^ exp_a;
    // Second half only exists in merge mode
    assign err1 = merge_en ? (ch1 ^ exp_b) : 32'h00000000;

    // Auto ordering flips when the crossed pairing matches and straight fails
    always @* begin
        swap_d = swap_q;
        if (!merge_en || !auto_order) begin
            swap_d = 1'b0;
        end else if (word_valid && !(ch0 == exp_a && ch1 == exp_b) &&
                     ch0 == exp_b && ch1 == exp_a) begin
            swap_d = !swap_q;
        end
    end

    // Routes still counted after every active mask
    always @* begin
        keep = 32'hFFFFFFFF;
        if (bw_ok) begin
            keep = keep & ~bw_blocked;
        end
        if (route_en) begin
            keep = keep & ~route_mask;
        end
        if (ext_act) begin
            keep = 32'h00000000;
        end
        if (skip_hit) begin
            keep = 32'h00000000;
        end
        // Restart wins over a word taken in the same cycle
        if (!word_valid || sync_restart) begin
            keep = 32'h00000000;
        end
    end

    // Masked routes contribute nothing to the sum
    assign ones0 = ones(err0 & keep);
    assign ones1 = ones(err1 & keep);
    assign add = {1'b0, ones0} + {1'b0, ones1};

    // Headroom before the total saturates, so the sum never wraps
    assign add_wide = {{(CW-7){1'b0}}, add};
    assign headroom = {CW{1'b1}} - err_count_q;

    // Pattern position; skipped words are not part of the pattern
    always @* begin
        pos_nx = pos_q + `EMASK_WORD_BITS;
        // Wrap at the per-channel length
        if (pos_nx >= len_ch) begin
            pos_nx = pos_nx - len_ch;
        end
        pos_d = pos_q;
        // Restart realigns to the first pattern bit
        if (sync_restart) begin
            pos_d = {LW{1'b0}};
        end else if (word_valid && !skip_hit) begin
            pos_d = pos_nx;
        end
    end

    // Count, order and position state
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pos_q <= {LW{1'b0}};
            swap_q <= 1'b0;
            err_add_q <= 7'h00;
            err_count_q <= {CW{1'b0}};
            exp_hold_q <= 1'b0;
        end else begin
            pos_q <= pos_d;
            swap_q <= swap_d;
            // Unmasked errors of the word taken at this edge
            err_add_q <= add;
            // Restart clears the total; saturate instead of wrapping
            if (sync_restart) begin
                err_count_q <= {CW{1'b0}};
            end else if (add_wide <= headroom) begin
                err_count_q <= err_count_q + add_wide;
            end else begin
                err_count_q <= {CW{1'b1}};
            end
            // Tells the expected-pattern source to stall one word
            exp_hold_q <= word_valid && skip_hit;
        end
    end

    // Effective settings; frame fields read zero outside frame mode
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            skip_on_q <= 1'b0;
            bwin_on_q <= 1'b0;
            ext_on_q <= 1'b0;
            frame_on_q <= 1'b0;
            frame_len_q <= {LW{1'b0}};
            frame_start_q <= {LW{1'b0}};
            frame_mask_q <= 32'h00000000;
        end else begin
            skip_on_q <= skip_ok;
            bwin_on_q <= bw_ok;
            ext_on_q <= ext_ok;
            frame_on_q <= frame_sel;
            // Copies freeze to zero so stale settings never leak out
            if (frame_sel) begin
                frame_len_q <= frame_len;
                frame_start_q <= frame_start;
                frame_mask_q <= frame_mask;
            end else begin
                frame_len_q <= {LW{1'b0}};
                frame_start_q <= {LW{1'b0}};
                frame_mask_q <= 32'h00000000;
            end
        end
    end
endmodule

// ===== verification/emask_chk.sv
// Port assertions for the error-count qualification block
`timescale 1ns/1ps
`include "emask_consts.vh"
module emask_chk #(
    parameter LW = 30,
    parameter CW = 48
) (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Settings
    input wire [2:0] pat_type,
    input wire [1:0] clk_src,
    input wire in_sel,
    input wire merge_en,
    input wire skip_en,
    input wire [2:0] skip_gen,
    input wire [1:0] sync_mode,
    input wire [LW-1:0] frame_len,
    input wire bwin_en,
    input wire route_en,
    input wire [31:0] route_mask,
    input wire [1:0] aux_func,
    input wire ext_en,
    input wire ext_mask_pin,
    // Words
    input wire word_valid,
    input wire sync_restart,
    input wire [31:0] rx_a,
    // Results
    input wire [CW-1:0] err_count_q,
    input wire [6:0] err_add_q,
    input wire exp_hold_q,
    input wire skip_on_q,
    input wire bwin_on_q,
    input wire ext_on_q,
    input wire frame_on_q,
    input wire [LW-1:0] frame_len_q
);
    reg [1:0] up_q;
    wire up = up_q == 2'h3;
    wire skip_ok = skip_en && pat_type == `EMASK_PAT_DATA && !in_sel &&
        clk_src == `EMASK_CLK_CDR && !merge_en;
    wire head8 = skip_gen < 3'h2 &&
        (rx_a & `EMASK_SKP_8B10B_MSK) == `EMASK_SKP_8B10B;
    wire frm = sync_mode == `EMASK_SYNC_FRAME;
    // Edges since release, so $past never reaches back into reset
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            up_q <= 2'h0;
        else if (!up)
            up_q <= up_q + 2'h1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence head_s;
        skip_on_q && word_valid && !sync_restart && head8;
    endsequence
    sequence next_s;
        word_valid && !sync_restart;
    endsequence
    skip_ok_a: assert property (up |-> skip_on_q == $past(skip_ok))
        else $error("skip filter enable wrong");
    bwin_ok_a: assert property (up |-> bwin_on_q == $past(bwin_en &&
        pat_type != `EMASK_PAT_PRBS && pat_type != `EMASK_PAT_MIXED))
        else $error("block window enable wrong");
    ext_ok_a: assert property (up |-> ext_on_q ==
        $past(ext_en && aux_func == `EMASK_AUX_EXTMASK))
        else $error("external mask enable wrong");
    frame_on_a: assert property (up |-> frame_on_q == $past(frm))
        else $error("frame mode flag wrong");
    frame_copy_a: assert property (up |-> frame_len_q ==
        ($past(frm) ? $past(frame_len) : {LW{1'b0}}))
        else $error("frame length copy wrong");
    idle_add_a: assert property (!word_valid || sync_restart |=>
        err_add_q == 7'h00)
        else $error("count added without a word");
    count_sum_a: assert property (up && !$past(sync_restart) &&
        !(&err_count_q) |-> err_count_q == $past(err_count_q) + err_add_q)
        else $error("total does not follow added count");
    skip_hold_a: assert property (exp_hold_q |-> err_add_q == 7'h00)
        else $error("skip word counted");
    skip_set_a: assert property (head_s ##1 next_s |->
        exp_hold_q [*2])
        else $error("short skip set not dropped");
    ext_mask_a: assert property ((ext_on_q && ext_mask_pin) [*3]
        ##0 (word_valid && ext_en && aux_func == `EMASK_AUX_EXTMASK) |=>
        err_add_q == 7'h00)
        else $error("errors counted under external mask");
    route_all_a: assert property ((route_en && &route_mask) [*2]
        ##0 word_valid |=> err_add_q == 7'h00)
        else $error("errors counted on masked routes");
endmodule
bind emask_top emask_chk #(.LW(LW), .CW(CW)) u_chk (.*);

// ===== verification/emask_src_model.sv
// Pattern source standing in for the transmitter under test
`timescale 1ns/1ps
module emask_src_model (
    // Pattern the source should send
    input wire [31:0] exp_a,
    input wire [31:0] exp_b,
    // Errors, skip words and wiring faults commanded by the bench
    input wire [31:0] err_a,
    input wire [31:0] err_b,
    input wire skip_ins,
    input wire [31:0] skip_word,
    input wire crossed,
    // Words as they arrive at the block
    output wire [31:0] rx_a,
    output wire [31:0] rx_b
);
    wire [31:0] tx_a = skip_ins ? skip_word : exp_a ^ err_a;
    wire [31:0] tx_b = exp_b ^ err_b;
    // Halves swap only on command; without auto order results are void
    assign rx_a = crossed ? tx_b : tx_a;
    assign rx_b = crossed ? tx_a : tx_b;
endmodule

// ===== verification/tb_error_count_masking.sv
// Self-checking bench for the error-count qualification block
`timescale 1ns/1ps
`include "emask_consts.vh"
`define CHK(nm, e, g) begin \
    checks_done = checks_done + 1; \
    if ((g) !== (e)) begin \
        $display("mismatch %0s expected %0h seen %0h", nm, e, g); \
        bad_count = bad_count + 1; \
    end \
end
module tb_error_count_masking;
    reg mclk = 1'b0, rst_n = 1'b0, in_sel = 1'b0, merge_en = 1'b0;
    reg auto_order = 1'b0, skip_en = 1'b0, bwin_en = 1'b0;
    reg bw_wr_en = 1'b0, bw_wr_data = 1'b0, route_en = 1'b0;
    reg ext_en = 1'b0, ext_mask_pin = 1'b0, word_valid = 1'b0;
    reg sync_restart = 1'b0, skip_ins = 1'b0, crossed = 1'b0;
    reg [2:0] pat_type = 3'h1, skip_gen = 3'h0;
    reg [1:0] clk_src = 2'h2, sync_mode = 2'h0, aux_func = 2'h0;
    reg [29:0] pat_len = 30'h100, frame_len = 30'h0, frame_start = 30'h0;
    reg [31:0] frame_mask = 32'h0, route_mask = 32'h0, exp_a, exp_b;
    reg [31:0] err_a = 32'h0, err_b = 32'h0, skip_word = 32'h0, ra, rb;
    reg [5:0] bw_wr_addr = 6'h0;
    reg [63:0] bw_mem;
    reg [47:0] total = 48'h0;
    wire [31:0] rx_a, rx_b, frame_mask_q;
    wire [47:0] err_count_q;
    wire [6:0] err_add_q;
    wire exp_hold_q, swap_q, skip_on_q, bwin_on_q, ext_on_q, frame_on_q;
    wire [29:0] frame_len_q, frame_start_q;
    integer bad_count = 0, checks_done = 0, cyc = 0, i, k;
    emask_top #(.BW_DEPTH(64), .BW_AW(6)) dut (.*);
    emask_src_model u_src (.*);
    // Clock, 25 ns period
    always #12.5 mclk = ~mclk;
    // Hang guard, far above the roughly 200 cycles the run needs
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 8000) begin
            bad_count = bad_count + 1;
            final_report;
        end
    end
    function [6:0] ones(input [31:0] w);
        integer j;
        begin
            ones = 7'h0;
            for (j = 0; j < 32; j = j + 1)
                ones = ones + w[j];
        end
    endfunction
    // Routes suppressed by the window for word w at step 1 << sh
    function [31:0] supp(input integer w, input integer sh);
        integer j;
        for (j = 0; j < 32; j = j + 1)
            supp[j] = bw_mem[(32 * w + j) >> sh];
    endfunction
    task final_report;
        begin
            $display("checks %0d mismatches %0d", checks_done, bad_count);
            if (bad_count == 0 && checks_done > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // One word; 7F as expected count means not checked
    task word(input [31:0] fa, input [31:0] fb, input [6:0] e);
        begin
            exp_a = $urandom;
            exp_b = $urandom;
            err_a = fa;
            err_b = fb;
            word_valid = 1'b1;
            @(negedge mclk);
            total = total + e;
            if (e != 7'h7F)
                `CHK("err_add", e, err_add_q)
        end
    endtask
    task idle;
        begin
            word_valid = 1'b0;
            @(negedge mclk);
        end
    endtask
    task settle;
        repeat (2) idle;
    endtask
    task restart;
        begin
            word_valid = 1'b0;
            sync_restart = 1'b1;
            @(negedge mclk);
            sync_restart = 1'b0;
            total = 48'h0;
            idle;
            `CHK("restart", 48'h0, err_count_q)
        end
    endtask
    task fin(input [63:0] nm);
        begin
            idle;
            `CHK("err_count", total, err_count_q)
            $display("test %0s done", nm);
        end
    endtask
    initial begin
        exp_a = $urandom(32'h774A);
        exp_b = 32'h0;
        repeat (6) @(negedge mclk);
        rst_n = 1'b1;
        restart;
        // Plain counting, single then merged, with full-word corners
        word(32'hFFFFFFFF, 32'h0, 7'h20);
        for (k = 0; k < 12; k = k + 1) begin
            ra = $urandom;
            rb = $urandom;
            merge_en = k > 5;
            word(ra, rb, ones(ra) + (merge_en ? ones(rb) : 7'h0));
        end
        word(32'hFFFFFFFF, 32'hFFFFFFFF, 7'h40);
        fin("basic");
        // Route mask, all routes first
        route_en = 1'b1;
        for (k = 0; k < 5; k = k + 1) begin
            route_mask = k == 0 ? 32'hFFFFFFFF : $urandom;
            settle;
            ra = $urandom;
            rb = $urandom;
            word(ra, rb, ones(ra & ~route_mask) +
                ones(rb & ~route_mask));
        end
        route_en = 1'b0;
        merge_en = 1'b0;
        fin("route");
        // External mask needs the aux function, then masks with the pin high until ext_en drops
        ext_en = 1'b1;
        settle;
        `CHK("ext_on", 1'b0, ext_on_q)
        aux_func = `EMASK_AUX_EXTMASK;
        ext_mask_pin = 1'b1;
        settle;
        `CHK("ext_on", 1'b1, ext_on_q)
        for (k = 0; k < 6; k = k + 1) begin
            ra = $urandom;
            if (k == 3)
                ext_en = 1'b0;
            word(ra, 32'h0, k < 3 ? 7'h0 : ones(ra));
        end
        ext_mask_pin = 1'b0;
        restart;
        fin("ext");
        // Skip filter refused for wrong pattern or path
        bwin_en = 1'b1;
        skip_en = 1'b1;
        for (k = 0; k < 8; k = k + 1) begin
            pat_type = k < 4 ? k[2:0] : 3'h1;
            in_sel = k == 5;
            clk_src = k == 6 ? 2'h1 : 2'h2;
            merge_en = k == 7;
            settle;
            `CHK("skip_on", k == 1 || k == 4, skip_on_q)
            `CHK("bwin_on", k != 0 && k != 3, bwin_on_q)
        end
        bwin_en = 1'b0;
        merge_en = 1'b0;
        // Each generation's set: head plus its words dropped, then data
        for (k = 0; k < 5; k = k + 1) begin
            skip_gen = k[2:0];
            settle;
            skip_ins = 1'b1;
            for (i = 0; i < (k < 2 ? 2 : 5); i = i + 1) begin
                skip_word = i > 0 ? $urandom : k < 2 ?
                    `EMASK_SKP_8B10B | ($urandom & 32'h3) : k < 4 ?
                    `EMASK_SKP_128B : `EMASK_SKP_G5;
                word($urandom, 32'h0, 7'h0);
                `CHK("hold", 1'b1, exp_hold_q)
            end
            skip_ins = 1'b0;
            ra = $urandom;
            word(ra, 32'h0, ones(ra));
        end
        skip_en = 1'b0;
        fin("skip");
        // Block window store, then step at length range boundaries
        for (k = 0; k < 64; k = k + 1) begin
            bw_wr_addr = k[5:0];
            bw_wr_data = $urandom;
            bw_mem[k] = bw_wr_data;
            bw_wr_en = 1'b1;
            @(negedge mclk);
        end
        bw_wr_en = 1'b0;
        bwin_en = 1'b1;
        for (k = 0; k < 5; k = k + 1) begin
            merge_en = k[1];
            pat_type = k == 4 ? 3'h0 : 3'h1;
            pat_len = k == 0 ? 30'h200000 : k == 1 ? 30'h200001 :
                k == 2 ? 30'h3FFFFC : 30'h400002;
            restart;
            for (i = 0; i < 2; i = i + 1) begin
                ra = $urandom;
                rb = merge_en ? $urandom : 32'h0;
                word(ra, rb, k == 4 ? ones(ra) :
                    ones(ra & ~supp(i, k & 1)) + ones(rb & ~supp(i, k & 1)));
            end
        end
        bwin_en = 1'b0;
        pat_type = 3'h1;
        fin("bwin");
        // Crossed halves found and put in order
        merge_en = 1'b1;
        auto_order = 1'b1;
        crossed = 1'b1;
        for (k = 0; k < 8; k = k + 1)
            word(32'h0, 32'h0, 7'h7F);
        `CHK("swap", 1'b1, swap_q)
        restart;
        ra = $urandom;
        word(ra, 32'h0, ones(ra));
        fin("order");
        // Frame settings pass only in frame mode
        for (k = 0; k < 2; k = k + 1) begin
            sync_mode = k ? `EMASK_SYNC_FRAME : `EMASK_SYNC_NORMAL;
            frame_len = $urandom;
            frame_start = $urandom;
            frame_mask = $urandom;
            settle;
            `CHK("f_len", k ? frame_len : 30'h0, frame_len_q)
            `CHK("f_start", k ? frame_start : 30'h0, frame_start_q)
            `CHK("f_mask", k ? frame_mask : 32'h0, frame_mask_q)
            `CHK("f_on", k, frame_on_q)
        end
        fin("frame");
        final_report;
    end
endmodule
